// ### hw/hfo_regs.svh
// Register map and constants of the internal oscillator control block.
// Assumes inclusion by the package and by the design modules only.
// Function
// RULE1 - Bit 7 enables the internal oscillator; resets to one.
// RULE2 - Read-only bit 6 reports oscillator running at programmed frequency; resets one.
// RULE3 - Writing one to bit 5 suspends; any wake event resumes.
// RULE4 - Read-only bit 4 high while wake timer unsafe; up to three timer clocks.
// RULE5 - Software avoids wake timer registers while the sync flag reads one.
// RULE6 - Bit 3 enables spread-spectrum dithering; resets to zero.
// RULE7 - Bits 1:0 select post divide 8, 4, 2, 1; reset 00.
// RULE8 - Bit 2 unused, reads zero, writes ignored.
// RULE9 - Crystal or resonator mode takes both crystal pins.
// RULE10 - Capacitor, RC or CMOS mode uses only the crystal output pin.
// RULE11 - Software selects external oscillator type and frequency range.
// RULE12 - Software makes the crossbar skip oscillator pins.
// RULE13 - Software sets pins analog, or digital input in CMOS mode.
// RULE14 - Dithering steps a triangle of period osc/384, updating every 32 cycles.
// RULE15 - Three-bit source select: 000 internal, 001 external.
// RULE16 - A wake event clears the suspend bit in hardware.
`ifndef HFO_REGS_SVH
`define HFO_REGS_SVH
`define HFO_CTRL_ADDR 8'ha9
`define HFO_CTRL_RESET 8'hc0
`define HFO_BIT_EN 7
`define HFO_BIT_RDY 6
`define HFO_BIT_SUSP 5
`define HFO_BIT_SYNC 4
`define HFO_BIT_DITH 3
`define HFO_DIV_MSB 1
`define HFO_DIV_LSB 0
`define HFO_DITH_STEP 32
`define HFO_DITH_STEPS 12
`define HFO_SYNC_CLKS 3
`define HFO_SETTLE 16
`define HFO_SRC_INT 3'h0
`define HFO_SRC_EXT 3'h1
`define HFO_XMODE_OFF 3'h0
`define HFO_XMODE_CMOS 3'h2
`define HFO_XMODE_CMOS2 3'h3
`define HFO_XMODE_RC 3'h4
`define HFO_XMODE_CAP 3'h5
`define HFO_XMODE_XTAL 3'h6
`define HFO_XMODE_CRYSTAL_OUT_PIN 3'h7
`endif

// ### hw/hfo_pkg.sv
// Types shared by the oscillator control modules.
// Assumes the constants header is on the include path.
`include "hfo_regs.svh"
package hfo_pkg;
    typedef enum logic [1:0] {
        HFO_RUN = 2'b00,
        HFO_SETTLING = 2'b01,
        HFO_SUSP = 2'b10,
        HFO_OFF = 2'b11
    } hfo_state_e;
    // Pin direction and routing for the two crystal pins
    typedef struct packed {
        logic xtalInUsed;
        logic xtalOutUsed;
        logic cmosInput;
    } hfo_pins_s;
endpackage

// ### hw/hfo_dither.sv
// Stepped triangle generator for spread-spectrum dithering.
// Assumes the clock here stands in for the oscillator clock.
`timescale 1ns/1ps
`include "hfo_regs.svh"
module hfo_dither
    import hfo_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic enable,
    output logic signed [3:0] trimOffset
);
    logic [4:0] cycleCnt_r, cycleCnt_nxt;
    logic [3:0] stepIdx_r, stepIdx_nxt;
    logic signed [3:0] trim_r, trim_nxt;

    // Step counter; 12 steps of 32 cycles give one 384-cycle period
    always_comb begin
        cycleCnt_nxt = cycleCnt_r;
        stepIdx_nxt = stepIdx_r;
        trim_nxt = trim_r;
        if (!enable) begin
            cycleCnt_nxt = 5'h00;
            stepIdx_nxt = 4'h0;
            trim_nxt = 4'sh0;
        end else if (cycleCnt_r == 5'(`HFO_DITH_STEP - 1)) begin // [RULE14]
            cycleCnt_nxt = 5'h00;
            stepIdx_nxt = (stepIdx_r == 4'(`HFO_DITH_STEPS - 1)) ? 4'h0 : stepIdx_r + 4'h1;
            // Triangle: 0,1,2,3,2,1,0,-1,-2,-3,-2,-1
            case (stepIdx_nxt)
                4'h0, 4'h6: trim_nxt = 4'sh0;
                4'h1, 4'h5: trim_nxt = 4'sh1;
                4'h2, 4'h4: trim_nxt = 4'sh2;
                4'h3: trim_nxt = 4'sh3;
                4'h7, 4'hb: trim_nxt = -4'sh1;
                4'h8, 4'ha: trim_nxt = -4'sh2;
                4'h9: trim_nxt = -4'sh3;
                default: trim_nxt = 4'sh0;
            endcase
        end else begin
            cycleCnt_nxt = cycleCnt_r + 5'h01;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cycleCnt_r <= 5'h00;
            stepIdx_r <= 4'h0;
            trim_r <= 4'sh0;
        end else begin
            cycleCnt_r <= cycleCnt_nxt;
            stepIdx_r <= stepIdx_nxt;
            trim_r <= trim_nxt;
        end
    end

    assign trimOffset = trim_r;
endmodule // hfo_dither

// ### hw/hf_oscillator_control.sv
// Control register and status logic of the internal high-frequency oscillator,
// plus crystal pin routing for the external drive circuit.
// Assumes the core register port below, and synchronous wake and timer inputs
// except the timer clock tick, which arrives from another domain.
`timescale 1ns/1ps
`include "hfo_regs.svh"
module hf_oscillator_control
    import hfo_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic wakeEvent,
    input wire logic wakeByTimer,
    input wire logic timerClkPin,
    input wire logic [2:0] extOscMode,
    input wire logic [2:0] clock_source_select,
    output logic hfOscRunning,
    output logic [1:0] hfPostDivide,
    output logic signed [3:0] ditherTrim,
    output logic sysClkFromExt,
    output hfo_pins_s pinRoute
);
    logic hfOscEnable_r, hfOscEnable_nxt;
    logic suspend_r, suspend_nxt;
    logic ditherEnable_r, ditherEnable_nxt;
    logic [1:0] postDiv_r, postDiv_nxt;
    logic ready_r, ready_nxt;
    logic [4:0] settle_r, settle_nxt;
    hfo_state_e state_r, state_nxt;
    logic syncFlag_r, syncFlag_nxt;
    logic [1:0] syncCnt_r, syncCnt_nxt;
    logic tmrMeta_r, tmrSync_r, tmrPrev_r;
    logic tmrEdge, ctrlWrite;
    logic [2:0] srcSel_r;
    hfo_pins_s pins_r, pins_nxt;
    logic [7:0] rdata_nxt;
    // Reset image of the control register; field resets are cut from it so they cannot drift
    localparam logic [7:0] CtrlReset = `HFO_CTRL_RESET;

    // Write strobe aimed at the control register
    assign ctrlWrite = regWrite && (regAddr == `HFO_CTRL_ADDR);

    // Timer clock from its own domain; two flops before edge detection
    // Edge detector resets low, as the timer clock idles low, so no false edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tmrMeta_r <= 1'b0;
            tmrSync_r <= 1'b0;
            tmrPrev_r <= 1'b0;
        end else begin
            tmrMeta_r <= timerClkPin;
            tmrSync_r <= tmrMeta_r;
            tmrPrev_r <= tmrSync_r;
        end
    end
    assign tmrEdge = tmrSync_r && !tmrPrev_r;

    // Software-written control fields; bit 2 is simply not stored
    always_comb begin
        hfOscEnable_nxt = hfOscEnable_r;
        ditherEnable_nxt = ditherEnable_r;
        postDiv_nxt = postDiv_r;
        suspend_nxt = suspend_r;
        if (ctrlWrite) begin
            hfOscEnable_nxt = regWdata[`HFO_BIT_EN]; // [RULE1]
            ditherEnable_nxt = regWdata[`HFO_BIT_DITH]; // [RULE6]
            postDiv_nxt = regWdata[`HFO_DIV_MSB:`HFO_DIV_LSB]; // [RULE7] [RULE8]
            if (regWdata[`HFO_BIT_SUSP])
                suspend_nxt = 1'b1; // [RULE3]
        end
        // Wake wins over a same-cycle suspend write so no wake is lost
        if (wakeEvent)
            suspend_nxt = 1'b0; // [RULE16]
    end

    // Oscillator state: settle after enable or wake before ready is reported
    // A suspend written while settling waits until the oscillator runs
    always_comb begin
        state_nxt = state_r;
        settle_nxt = settle_r;
        ready_nxt = ready_r;
        case (state_r)
            HFO_RUN: begin
                ready_nxt = 1'b1;
                if (!hfOscEnable_r) begin
                    state_nxt = HFO_OFF;
                    ready_nxt = 1'b0;
                end else if (suspend_r) begin
                    state_nxt = HFO_SUSP; // [RULE3]
                    ready_nxt = 1'b0;
                end
            end
            HFO_SETTLING: begin
                ready_nxt = 1'b0;
                if (!hfOscEnable_r) begin
                    state_nxt = HFO_OFF;
                end else if (settle_r == 5'(`HFO_SETTLE - 1)) begin
                    state_nxt = HFO_RUN;
                    ready_nxt = 1'b1; // [RULE2]
                end else begin
                    settle_nxt = settle_r + 5'h01;
                end
            end
            HFO_SUSP: begin
                ready_nxt = 1'b0;
                settle_nxt = 5'h00;
                if (!suspend_r)
                    state_nxt = HFO_SETTLING; // [RULE3]
            end
            HFO_OFF: begin
                ready_nxt = 1'b0;
                settle_nxt = 5'h00;
                if (hfOscEnable_r)
                    state_nxt = HFO_SETTLING;
            end
            default: begin
                state_nxt = HFO_OFF;
                ready_nxt = 1'b0;
            end
        endcase
    end

    // Wake timer sync flag: busy for three timer clocks after a non-timer wake
    always_comb begin
        syncFlag_nxt = syncFlag_r;
        syncCnt_nxt = syncCnt_r;
        if (wakeEvent && suspend_r && !wakeByTimer) begin
            syncFlag_nxt = 1'b1; // [RULE4]
            syncCnt_nxt = 2'h0;
        end else if (syncFlag_r && tmrEdge) begin
            if (syncCnt_r == 2'(`HFO_SYNC_CLKS - 1)) begin
                syncFlag_nxt = 1'b0; // [RULE4]
                syncCnt_nxt = 2'h0;
            end else begin
                syncCnt_nxt = syncCnt_r + 2'h1;
            end
        end
    end

    // Pin takeover follows the external oscillator mode
    always_comb begin
        pins_nxt = '0;
        case (extOscMode)
            `HFO_XMODE_XTAL, `HFO_XMODE_CRYSTAL_OUT_PIN: begin
                pins_nxt.xtalInUsed = 1'b1; // [RULE9]
                pins_nxt.xtalOutUsed = 1'b1;
            end
            `HFO_XMODE_RC, `HFO_XMODE_CAP: begin
                pins_nxt.xtalOutUsed = 1'b1; // [RULE10]
            end
            `HFO_XMODE_CMOS, `HFO_XMODE_CMOS2: begin
                pins_nxt.xtalOutUsed = 1'b1; // [RULE10]
                pins_nxt.cmosInput = 1'b1;
            end
            default: pins_nxt = '0;
        endcase
    end

    // Read data; unused bit 2 reads zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (regAddr == `HFO_CTRL_ADDR) begin
            rdata_nxt[`HFO_BIT_EN] = hfOscEnable_r;
            rdata_nxt[`HFO_BIT_RDY] = ready_r; // [RULE2]
            rdata_nxt[`HFO_BIT_SUSP] = suspend_r;
            rdata_nxt[`HFO_BIT_SYNC] = syncFlag_r; // [RULE4]
            rdata_nxt[`HFO_BIT_DITH] = ditherEnable_r;
            rdata_nxt[`HFO_DIV_MSB:`HFO_DIV_LSB] = postDiv_r; // [RULE8]
        end
    end

    // Register every group of state except the timer clock synchronizer flops; field resets come from the reset image
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            hfOscEnable_r <= CtrlReset[`HFO_BIT_EN]; // [RULE1]
            suspend_r <= CtrlReset[`HFO_BIT_SUSP];
            ditherEnable_r <= CtrlReset[`HFO_BIT_DITH]; // [RULE6]
            postDiv_r <= CtrlReset[`HFO_DIV_MSB:`HFO_DIV_LSB]; // [RULE7]
            ready_r <= CtrlReset[`HFO_BIT_RDY]; // [RULE2]
            settle_r <= 5'h00;
            state_r <= HFO_RUN;
            syncFlag_r <= CtrlReset[`HFO_BIT_SYNC];
            syncCnt_r <= 2'h0;
            srcSel_r <= `HFO_SRC_INT;
            pins_r <= '0;
            regRdata <= 8'h00;
        end else begin
            hfOscEnable_r <= hfOscEnable_nxt;
            suspend_r <= suspend_nxt;
            ditherEnable_r <= ditherEnable_nxt;
            postDiv_r <= postDiv_nxt;
            ready_r <= ready_nxt;
            settle_r <= settle_nxt;
            state_r <= state_nxt;
            syncFlag_r <= syncFlag_nxt;
            syncCnt_r <= syncCnt_nxt;
            srcSel_r <= clock_source_select;
            pins_r <= pins_nxt;
            regRdata <= rdata_nxt;
        end
    end

    // Dither only while the oscillator actually runs
    // Trim restarts from zero whenever the oscillator leaves run
    hfo_dither u_dither (
        .clock(clock),
        .rst(rst),
        .enable(ditherEnable_r && (state_r == HFO_RUN)), // [RULE14]
        .trimOffset(ditherTrim)
    );

    // Status outputs and pin routing
    assign hfOscRunning = (state_r == HFO_RUN);
    assign hfPostDivide = postDiv_r; // [RULE7]
    assign sysClkFromExt = (srcSel_r == `HFO_SRC_EXT); // [RULE15]
    assign pinRoute = pins_r;
endmodule // hf_oscillator_control

// ### verification/hfo_osc_model.sv
// Far-side source model: free-running low-rate wake timer clock.
// Assumes the bench ties its output to the timer clock pin.
`timescale 1ns/1ps
module hfo_osc_model (
    output logic timerClk
);
    // Odd half period keeps its phase unrelated to the core clock
    initial begin
        timerClk = 1'b0;
        forever #37 timerClk = ~timerClk;
    end
endmodule // hfo_osc_model

// ### verification/hfo_checker.sv
// Port assertions for the oscillator control block.
// Assumes binding to the top module, one clock domain.
`timescale 1ns/1ps
module hfo_checker
    import hfo_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic wakeEvent,
    input wire logic [2:0] extOscMode,
    input wire logic [2:0] clock_source_select,
    input wire logic hfOscRunning,
    input wire logic [1:0] hfPostDivide,
    input wire logic signed [3:0] ditherTrim,
    input wire logic sysClkFromExt,
    input wire hfo_pins_s pinRoute
);
    logic wr;
    // Write strobe aimed at the control register
    assign wr = regWrite && regAddr == 8'ha9;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Register and status relations
    AST_UNUSED_ZERO: assert property (
        regRdata[2] == 1'b0) else $error("unused bit read as one");
    AST_DIVIDE: assert property (
        wr ##1 !wr ##1 !wr |-> hfPostDivide == $past(regWdata[1:0], 2))
        else $error("post divide not taken from write");
    AST_SUSPEND: assert property (
        wr && regWdata[5] && !wakeEvent ##1 !wakeEvent [*3] |-> !hfOscRunning)
        else $error("oscillator still running in suspend");
    AST_WAKE_CLEARS: assert property (
        wakeEvent && !wr ##1 regAddr == 8'ha9 |=> !regRdata[5])
        else $error("suspend bit not cleared by wake");
    AST_READY: assert property (
        wakeEvent && regAddr == 8'ha9 && regRdata[7] |-> ##[2:24] regRdata[6])
        else $error("ready flag late after wake");
    AST_SYNC_BOUND: assert property (
        $rose(regRdata[4]) |-> ##[1:80] !regRdata[4])
        else $error("sync flag stuck");
    AST_SOURCE: assert property (
        sysClkFromExt == ($past(clock_source_select) == 3'h1))
        else $error("source select decode wrong");
    AST_PIN_XTAL: assert property (
        extOscMode[2:1] == 2'b11 |=> pinRoute == 3'b110)
        else $error("crystal mode pins wrong");
    AST_PIN_ONE: assert property (
        extOscMode inside {[3'h2:3'h5]} |=> pinRoute.xtalOutUsed && !pinRoute.xtalInUsed)
        else $error("single pin mode wrong");
    AST_TRIM_RANGE: assert property (
        ditherTrim <= 4'sd3 && ditherTrim >= -4'sd3) else $error("trim out of range");
endmodule // hfo_checker
bind hf_oscillator_control hfo_checker chk_u (.clock, .rst, .regAddr, .regWrite,
    .regWdata, .regRdata, .wakeEvent, .extOscMode, .clock_source_select,
    .hfOscRunning, .hfPostDivide, .ditherTrim, .sysClkFromExt, .pinRoute);

// ### verification/hf_oscillator_control_tb.sv
// Self-checking bench for the oscillator control block.
// Assumes the package, design and timer source model are compiled first.
`timescale 1ns/1ps
module hf_oscillator_control_tb
    import hfo_pkg::*;
;
    logic clock, rst, regWrite, wakeEvent, wakeByTimer, timerClkPin;
    logic [7:0] regAddr, regWdata, regRdata, r;
    logic [2:0] extOscMode, clock_source_select;
    logic hfOscRunning, sysClkFromExt;
    logic [1:0] hfPostDivide;
    logic signed [3:0] ditherTrim, mx, mn;
    hfo_pins_s pinRoute;
    int err_total, n_tests;
    logic [7:0] rowW [6] = '{8'h83, 8'h8a, 8'h8e, 8'h81, 8'hd0, 8'h80};
    logic [7:0] rowR [6] = '{8'hc3, 8'hca, 8'hca, 8'hc1, 8'hc0, 8'hc0};
    hf_oscillator_control dut_u (.clock, .rst, .regAddr, .regWrite, .regWdata,
        .regRdata, .wakeEvent, .wakeByTimer, .timerClkPin, .extOscMode,
        .clock_source_select, .hfOscRunning, .hfPostDivide, .ditherTrim,
        .sysClkFromExt, .pinRoute);
    hfo_osc_model src_u (.timerClk(timerClkPin));
    // Clock, 8 ns period
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Write one byte; address is left for the next call to set
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr <= a;
        regWrite <= 1'b1;
        regWdata <= d;
        @(posedge clock);
        regWrite <= 1'b0;
    endtask
    // Read data lags the address by one edge
    task automatic rd(input logic [7:0] a);
        regAddr <= a;
        repeat (2) @(posedge clock);
        r = regRdata;
    endtask
    // Bounded wait on a control register bit
    task automatic waitBit(input int b, input logic v, input int lim);
        for (int k = 0; k < lim && regRdata[b] !== v; k++) @(posedge clock);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Watchdog, well above the expected run of some 1000 cycles
    initial begin
        #60000;
        err_total++;
        end_of_test;
    end
    // Main sequence
    initial begin
        {rst, regWrite, wakeEvent, wakeByTimer} = 4'h8;
        {regAddr, regWdata, extOscMode, clock_source_select} = {8'ha9, 8'h00, 6'h00};
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        rd(8'ha9);
        chk("reset", 8'hc0, r);
        rd(8'h55);
        chk("unmapped", 8'h00, r);
        wr(8'h55, 8'h03);
        rd(8'ha9);
        chk("ignored", 8'hc0, r);
        for (int i = 0; i < 6; i++) begin
            wr(8'ha9, rowW[i]);
            rd(8'ha9);
            chk("ctrl", rowR[i], r);
            chk("divide", {6'h0, rowW[i][1:0]}, {6'h0, hfPostDivide});
        end
        wr(8'ha9, 8'ha0);
        repeat (3) @(posedge clock);
        chk("running", 8'h00, {7'h0, hfOscRunning});
        chk("ready", 8'h00, {7'h0, regRdata[6]});
        wakeEvent <= 1'b1;
        @(posedge clock);
        wakeEvent <= 1'b0;
        repeat (2) @(posedge clock);
        chk("suspend", 8'h00, {7'h0, regRdata[5]});
        chk("sync", 8'h01, {7'h0, regRdata[4]});
        waitBit(4, 1'b0, 80);
        chk("sync", 8'h00, {7'h0, regRdata[4]});
        waitBit(6, 1'b1, 24);
        chk("ready", 8'h01, {7'h0, regRdata[6]});
        wr(8'ha9, 8'ha0);
        repeat (3) @(posedge clock);
        {wakeEvent, wakeByTimer} <= 2'b11;
        @(posedge clock);
        {wakeEvent, wakeByTimer} <= 2'b00;
        repeat (2) @(posedge clock);
        chk("timer wake", 8'h00, {7'h0, regRdata[4]});
        waitBit(6, 1'b1, 24);
        wr(8'ha9, 8'h00);
        rd(8'ha9);
        rd(8'ha9);
        chk("off", 8'h00, r);
        chk("running", 8'h00, {7'h0, hfOscRunning});
        wr(8'ha9, 8'h88);
        waitBit(6, 1'b1, 24);
        chk("ready", 8'h01, {7'h0, regRdata[6]});
        {mx, mn} = 8'h00;
        repeat (900) begin
            @(posedge clock);
            mx = (ditherTrim > mx) ? ditherTrim : mx;
            mn = (ditherTrim < mn) ? ditherTrim : mn;
        end
        chk("trim max", 8'h03, {4'h0, mx});
        chk("trim min", 8'h0d, {4'h0, mn});
        // Mode 1 is reserved, so it is left out
        for (int m = 0; m < 8; m++) begin
            if (m != 1) begin
                extOscMode <= 3'(m);
                repeat (2) @(posedge clock);
                chk("pins", {5'h0, m >= 6, m >= 2, m == 2 || m == 3}, 8'(pinRoute));
            end
        end
        for (int s = 0; s < 2; s++) begin
            clock_source_select <= 3'(s);
            repeat (2) @(posedge clock);
            chk("source", 8'(s), {7'h0, sysClkFromExt});
        end
        wr(8'ha9, 8'h83);
        {rst, clock_source_select} <= 4'h8;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(8'ha9);
        chk("reset again", 8'hc0, r);
        end_of_test;
    end
endmodule // hf_oscillator_control_tb
